// [udc_crc.sv]
/*
  running crc over one data word per enable, msb first.
  assumes init and enable never arrive together.
*/
`timescale 1ns/1ns
module udc_crc
  import udc_pkg::*;
#(
  parameter int          W    = 16,
  parameter logic [15:0] POLY = UDC_CRC_POLY,
  parameter logic [15:0] SEED = UDC_CRC_SEED
)
(
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_init,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_data,
  output logic [15:0]       o_crc
);

  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;

  // ==========================================================
  // bitwise update unrolled by the loop, one word per cycle
  always_comb
  begin
    logic fb;
    fb      = 1'b0;
    nxt_crc = crc_ff;
    if (i_init)
    begin
      nxt_crc = SEED;
    end
    else if (i_en)
    begin
      for (int i = W - 1; i >= 0; i--)
      begin
        fb      = nxt_crc[15] ^ i_data[i];
        nxt_crc = {nxt_crc[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      crc_ff <= SEED;
    end
    else
    begin
      crc_ff <= nxt_crc;
    end
  end

  assign o_crc = crc_ff;

endmodule

// [udc_ctrl.sv]
/*
  ultra dma mode selection and data-out burst crc checking, device side.
  assumes commands come from the device's own decoder on i_clk and the host
  pins arrive asynchronously; the host strobe is far slower than i_clk.
*/
`timescale 1ns/1ns
module udc_ctrl
  import udc_pkg::*;
#(
  parameter logic [2:0] MAX_MODE     = UDC_MAX_MODE,
  parameter bit         ABORT_ON_CRC = 1'b0,
  parameter int         FIFO_DEPTH   = 4
)
(
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_cmd_valid,
  input  wire udc_cmd_s               i_cmd,
  input  wire udc_pins_s              i_pins,
  input  wire logic                   i_rd_ready,
  input  wire logic                   i_intrq_clr,
  output logic                        o_dmarq,
  output logic                        o_ddmardy_n,
  output logic                        o_ddmardy_oe,
  output logic [15:0]                 o_ident_udma,
  output logic [UDC_MODE_W-1:0]       o_mwdma_mode,
  output udc_status_s                 o_status,
  output logic                        o_busy,
  output logic                        o_cmd_done,
  output logic                        o_cmd_fail,
  output logic                        o_intrq,
  output logic                        o_rd_valid,
  output logic [UDC_DW-1:0]           o_rd_data
);

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_REQ,
    ST_BURST,
    ST_CRC,
    ST_END
  } udc_state_e;

  localparam int LW = $clog2(FIFO_DEPTH+1);

  // ==========================================================
  // pin synchroniser: two stages, then one history stage
  udc_pins_s sync1_ff;
  udc_pins_s sync2_ff;
  udc_pins_s hist_ff;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_ff <= '{hw_rst_n: 1'b1, dmack_n: 1'b1, default: '0};
      sync2_ff <= '{hw_rst_n: 1'b1, dmack_n: 1'b1, default: '0};
      hist_ff  <= '{hw_rst_n: 1'b1, dmack_n: 1'b1, default: '0};
    end
    else
    begin
      sync1_ff <= i_pins;
      sync2_ff <= sync1_ff;
      hist_ff  <= sync2_ff;
    end
  end

  // edges seen only after the second stage
  logic strobe_edge;
  logic ack_rise;
  logic hw_rst;
  assign strobe_edge = sync2_ff.hstrobe ^ hist_ff.hstrobe;
  assign ack_rise    = sync2_ff.dmack_n & ~hist_ff.dmack_n;
  assign hw_rst      = ~sync2_ff.hw_rst_n;

  // ==========================================================
  // state of the mode selection and the command in flight
  udc_state_e             st_ff,      nxt_st;
  logic                   mvld_ff,    nxt_mvld;
  logic [UDC_MODE_W-1:0]  mode_ff,    nxt_mode;
  logic                   revert_ff,  nxt_revert;
  logic [UDC_CNT_W-1:0]   left_ff,    nxt_left;
  logic [UDC_BURST_W-1:0] burst_ff,   nxt_burst;
  logic                   err_ff,     nxt_err;
  logic [UDC_BURST_W-1:0] errb_ff,    nxt_errb;
  logic                   abort_ff,   nxt_abort;
  logic [15:0]            hcrc_ff,    nxt_hcrc;
  logic                   dmarq_ff,   nxt_dmarq;
  logic                   pause_ff,   nxt_pause;
  logic                   oe_ff,      nxt_oe;
  logic                   done_ff,    nxt_done;
  logic                   fail_ff,    nxt_fail;
  logic                   intrq_ff,   nxt_intrq;
  logic [15:0]            ident_ff,   nxt_ident;
  logic                   busy_ff,    nxt_busy;

  logic                   crc_init;
  logic                   take;
  logic [15:0]            dev_crc;
  logic                   fifo_in_ready;
  logic [LW-1:0]          fifo_level;
  logic                   in_burst;

  // data words count only inside a properly opened burst
  assign in_burst = mvld_ff & dmarq_ff & ~sync2_ff.dmack_n;
  assign take     = (st_ff == ST_BURST) & in_burst & strobe_edge & (left_ff != '0);
  assign crc_init = (st_ff == ST_REQ) & ~sync2_ff.dmack_n;

  // ==========================================================
  // next-state logic
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_mvld   = mvld_ff;
    nxt_mode   = mode_ff;
    nxt_revert = revert_ff;
    nxt_left   = left_ff;
    nxt_burst  = burst_ff;
    nxt_err    = err_ff;
    nxt_errb   = errb_ff;
    nxt_abort  = abort_ff;
    nxt_hcrc   = hcrc_ff;
    nxt_dmarq  = dmarq_ff;
    nxt_done   = 1'b0;
    nxt_fail   = 1'b0;
    // set beats a clear arriving in the same cycle
    nxt_intrq  = (intrq_ff & ~i_intrq_clr) | (st_ff == ST_END);
    case (st_ff)
      ST_IDLE:
      begin
        nxt_dmarq = 1'b0;
        if (i_cmd_valid)
        begin
          nxt_done = 1'b1;
          case (i_cmd.op)
            UDC_CMD_SET_MODE:
            begin
              // any mode up to the fastest is accepted; the newest wins
              if (i_cmd.mode <= MAX_MODE)
              begin
                nxt_mvld = 1'b1;
                nxt_mode = i_cmd.mode;
              end
              else
              begin
                nxt_fail = 1'b1;
              end
            end
            UDC_CMD_REVERT_ON:  nxt_revert = 1'b1;
            UDC_CMD_REVERT_OFF: nxt_revert = 1'b0;
            UDC_CMD_SOFT_RST,
            UDC_CMD_DEV_RST:
            begin
              // mode survives unless reverting was enabled
              if (revert_ff)
              begin
                nxt_mvld = 1'b0;
              end
            end
            UDC_CMD_WRITE_DMA:
            begin
              if (mvld_ff && i_cmd.count != '0)
              begin
                nxt_done  = 1'b0;
                nxt_left  = i_cmd.count;
                nxt_burst = '0;
                nxt_err   = 1'b0;
                nxt_errb  = '0;
                nxt_abort = 1'b0;
                nxt_st    = ST_REQ;
              end
              else
              begin
                nxt_fail = 1'b1;
              end
            end
            default:
            begin
              nxt_fail = 1'b1;
            end
          endcase
        end
      end
      ST_REQ:
      begin
        nxt_dmarq = 1'b1;
        if (!sync2_ff.dmack_n)
        begin
          nxt_burst = burst_ff + 1'b1;
          nxt_st    = ST_BURST;
        end
      end
      ST_BURST:
      begin
        if (take)
        begin
          nxt_left = left_ff - 1'b1;
        end
        // last word taken: stop requesting so the host closes the burst
        if (take && left_ff == 16'h0001)
        begin
          nxt_dmarq = 1'b0;
        end
        if (ack_rise)
        begin
          // host crc is on the bus while it lifts its acknowledge
          nxt_hcrc  = sync2_ff.hd;
          nxt_dmarq = 1'b0;
          nxt_st    = ST_CRC;
        end
      end
      ST_CRC:
      begin
        if (hcrc_ff != dev_crc)
        begin
          if (!err_ff)
          begin
            nxt_err  = 1'b1;
            nxt_errb = burst_ff;
          end
          nxt_abort = ABORT_ON_CRC;
        end
        if (left_ff == '0 || (ABORT_ON_CRC && (hcrc_ff != dev_crc)))
        begin
          nxt_st = ST_END;
        end
        else
        begin
          nxt_st = ST_REQ;
        end
      end
      ST_END:
      begin
        nxt_done = 1'b1;
        nxt_fail = abort_ff | err_ff;
        nxt_st   = ST_IDLE;
      end
      default:
      begin
        nxt_st = ST_IDLE;
      end
    endcase
    // hardware reset from the pin, once through both synchroniser stages, drops the ultra mode in any state
    if (hw_rst)
    begin
      nxt_mvld   = 1'b0;
      nxt_revert = UDC_REVERT_RST;
      nxt_dmarq  = 1'b0;
      nxt_st     = ST_IDLE;
    end
  end

  // ==========================================================
  // pause and ident: pause early since the host may send a few more words
  always_comb
  begin
    nxt_pause = (fifo_level >= LW'(UDC_PAUSE_LVL)) | ~fifo_in_ready;
    nxt_oe    = (st_ff == ST_BURST) & in_burst;
    nxt_busy  = (nxt_st != ST_IDLE);
    nxt_ident = '0;
    for (int m = 0; m < 8; m++)
    begin
      nxt_ident[UDC_ID_SUP_LSB + m] = (3'(m) <= MAX_MODE);
      // taken from the next values so the word moves together with the status
      nxt_ident[UDC_ID_SEL_LSB + m] = nxt_mvld & (nxt_mode == 3'(m));
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_ff     <= ST_IDLE;
      mvld_ff   <= 1'b0;
      mode_ff   <= '0;
      revert_ff <= UDC_REVERT_RST;
      left_ff   <= '0;
      burst_ff  <= '0;
      err_ff    <= 1'b0;
      errb_ff   <= '0;
      abort_ff  <= 1'b0;
      hcrc_ff   <= '0;
      dmarq_ff  <= 1'b0;
      pause_ff  <= 1'b0;
      oe_ff     <= 1'b0;
      done_ff   <= 1'b0;
      fail_ff   <= 1'b0;
      intrq_ff  <= 1'b0;
      ident_ff  <= '0;
      busy_ff   <= 1'b0;
    end
    else
    begin
      st_ff     <= nxt_st;
      mvld_ff   <= nxt_mvld;
      mode_ff   <= nxt_mode;
      revert_ff <= nxt_revert;
      left_ff   <= nxt_left;
      burst_ff  <= nxt_burst;
      err_ff    <= nxt_err;
      errb_ff   <= nxt_errb;
      abort_ff  <= nxt_abort;
      hcrc_ff   <= nxt_hcrc;
      dmarq_ff  <= nxt_dmarq;
      pause_ff  <= nxt_pause;
      oe_ff     <= nxt_oe;
      done_ff   <= nxt_done;
      fail_ff   <= nxt_fail;
      intrq_ff  <= nxt_intrq;
      ident_ff  <= nxt_ident;
      busy_ff   <= nxt_busy;
    end
  end

  // ==========================================================
  // device crc over every word taken in the burst
  udc_crc #(
    .W    (UDC_DW)
  ) u_crc (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_init   (crc_init),
    .i_en     (take),
    .i_data   (sync2_ff.hd),
    .o_crc    (dev_crc)
  );

  // received words wait here for the device side to drain them
  udc_fifo #(
    .W (UDC_DW),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (take),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (sync2_ff.hd),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data),
    .o_level     (fifo_level)
  );

  // ==========================================================
  // outputs
  assign o_dmarq      = dmarq_ff;
  assign o_ddmardy_n  = pause_ff;
  assign o_ddmardy_oe = oe_ff;
  assign o_ident_udma = ident_ff;
  assign o_mwdma_mode = UDC_MW_DFLT;
  assign o_status     = '{udma_vld: mvld_ff, udma_mode: mode_ff, revert_en: revert_ff,
                          crc_err: err_ff, err_burst: errb_ff};
  assign o_busy       = busy_ff;
  assign o_cmd_done   = done_ff;
  assign o_cmd_fail   = fail_ff;
  assign o_intrq      = intrq_ff;

endmodule

// [udc_ctrl_asserts.sv]
/*
  checker for udc_ctrl: mode selection, reset handling and crc reporting.
  assumes it is bound onto udc_ctrl and sees one clock domain only.
*/
`timescale 1ns/1ns
module udc_ctrl_asserts
  import udc_pkg::*;
#(
  parameter logic [2:0] MAX_MODE = UDC_MAX_MODE
)
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_cmd_valid,
  input  wire udc_cmd_s    i_cmd,
  input  wire udc_pins_s   i_pins,
  input  wire logic        o_dmarq,
  input  wire logic        o_ddmardy_n,
  input  wire logic        o_ddmardy_oe,
  input  wire logic [15:0] o_ident_udma,
  input  wire udc_status_s o_status,
  input  wire logic        o_busy,
  input  wire logic        o_cmd_done,
  input  wire logic        o_cmd_fail
);
  localparam logic [7:0] SUP = 8'((16'h2 << MAX_MODE) - 16'h1);
  logic tk;
  logic rst_cmd;
  // ==========================================================
  // helpers: a command is taken only while idle
  assign tk      = i_cmd_valid && !o_busy;
  assign rst_cmd = tk && (i_cmd.op == UDC_CMD_SOFT_RST || i_cmd.op == UDC_CMD_DEV_RST);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================================
  // mode selection, reset behaviour, dma request, crc error reporting and ready drive
  sup_bits_a: assert property ($past(i_arst_n) |-> o_ident_udma[7:0] == SUP)
    else $error("supported mode bits wrong");
  sel_word_a: assert property (o_ident_udma[15:8] == (o_status.udma_vld ? 8'h1 << o_status.udma_mode : 8'h0))
    else $error("selected mode bits disagree with status");
  mode_set_a: assert property (tk && i_cmd.op == UDC_CMD_SET_MODE && i_cmd.mode <= MAX_MODE |=>
    o_cmd_done && !o_cmd_fail && o_status.udma_vld && o_status.udma_mode == $past(i_cmd.mode))
    else $error("legal mode not taken");
  mode_bad_a: assert property (tk && i_cmd.op == UDC_CMD_SET_MODE && i_cmd.mode > MAX_MODE |=>
    o_cmd_done && o_cmd_fail && $stable(o_status.udma_mode) && $stable(o_status.udma_vld))
    else $error("too fast mode not refused");
  keep_mode_a: assert property (rst_cmd && !o_status.revert_en |=>
    $stable(o_status.udma_vld) && $stable(o_status.udma_mode))
    else $error("mode lost over soft reset");
  revert_drop_a: assert property (rst_cmd && o_status.revert_en |=> !o_status.udma_vld)
    else $error("mode kept with revert enabled");
  hw_clear_a: assert property (!i_pins.hw_rst_n [*4] |-> !o_status.udma_vld && !o_status.revert_en)
    else $error("hardware reset left mode set");
  dmarq_mode_a: assert property (o_dmarq |-> o_status.udma_vld && o_busy)
    else $error("dma request without mode or command");
  err_idx_a: assert property (o_status.crc_err |-> o_status.err_burst != 8'h0)
    else $error("crc error without burst index");
  first_err_a: assert property (o_status.crc_err && $past(o_status.crc_err) |-> $stable(o_status.err_burst))
    else $error("later crc error replaced first");
  oe_burst_a: assert property (o_ddmardy_oe |-> $past(o_dmarq))
    else $error("ready driven outside an open burst");
  // ==========================================================
  // main scenarios reached
  cov_set_c: cover property (tk && i_cmd.op == UDC_CMD_SET_MODE);
  cov_err_c: cover property ($rose(o_status.crc_err));
  cov_pause_c: cover property (o_ddmardy_oe && o_ddmardy_n);
endmodule

bind udc_ctrl udc_ctrl_asserts #(.MAX_MODE(MAX_MODE)) u_udc_ctrl_asserts (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .i_pins(i_pins), .o_dmarq(o_dmarq), .o_ddmardy_n(o_ddmardy_n), .o_ddmardy_oe(o_ddmardy_oe),
  .o_ident_udma(o_ident_udma), .o_status(o_status), .o_busy(o_busy),
  .o_cmd_done(o_cmd_done), .o_cmd_fail(o_cmd_fail));

// [udc_ctrl_tb_top.sv]
/*
  self-checking bench for udc_ctrl with the behavioural host on its pins.
  assumes default parameters: modes 0..6, no abort on crc error, fifo of 4 words.
*/
`timescale 1ns/1ns
module udc_ctrl_tb_top
  import udc_pkg::*;
();
  logic        i_clk = 1'b0, i_arst_n = 1'b0, i_cmd_valid = 1'b0, i_rd_ready = 1'b0;
  logic        i_intrq_clr = 1'b0, hw_rst_n = 1'b1, stall = 1'b0;
  udc_cmd_s    i_cmd = '0;
  udc_pins_s   pins;
  logic [15:0] base = 16'h0, total = 16'h0, blen = 16'h1, ident, rd_data;
  logic [7:0]  bad = 8'h0;
  logic [2:0]  mw;
  udc_status_s status;
  logic        dmarq, ddmardy_n, ddmardy_oe, busy, done, fail, intrq, rd_valid;
  int          failures = 0, tests_run = 0;
  integer      seed = 88;
  logic [15:0] word_q[$];
  logic        done_q[$];

  always #5 i_clk = ~i_clk;

  udc_ctrl u_udc_ctrl (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_pins(pins), .i_rd_ready(i_rd_ready), .i_intrq_clr(i_intrq_clr), .o_dmarq(dmarq),
    .o_ddmardy_n(ddmardy_n), .o_ddmardy_oe(ddmardy_oe), .o_ident_udma(ident), .o_mwdma_mode(mw),
    .o_status(status), .o_busy(busy), .o_cmd_done(done), .o_cmd_fail(fail), .o_intrq(intrq),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data));
  udc_host_model u_udc_host_model (.i_dmarq(dmarq), .i_ddmardy_n(ddmardy_n), .i_hw_rst_n(hw_rst_n),
    .i_base(base), .i_total(total), .i_burst_len(blen), .i_bad_mask(bad), .o_pins(pins));

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // issue one command, note its expected fail flag, wait until idle
  task automatic do_cmd(input udc_cmd_e op, input logic [2:0] m, input logic [15:0] c, input logic f);
    int n;
    n = 0;
    i_cmd_valid <= 1'b1;
    i_cmd <= '{op: op, mode: m, count: c};
    done_q.push_back(f);
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    while (busy !== 1'b0 && n < 20000)
    begin
      @(posedge i_clk);
      n++;
    end
    cmp_val(16'(n >= 20000), 16'h0);
    repeat (2) @(posedge i_clk);
  endtask

  // one write command; bm marks bursts whose crc the host spoils
  task automatic run_dma(input logic [15:0] n, input logic [15:0] bl, input logic [7:0] bm, input logic st,
                         input logic [7:0] eb);
    base <= 16'($random(seed));
    total <= n;
    blen <= bl;
    bad <= bm;
    stall <= st;
    @(posedge i_clk);
    for (int k = 0; k < n; k++)
      word_q.push_back(base + 16'(k));
    if (st)
      fork
        begin
          repeat (300) @(posedge i_clk);
          cmp_val({15'h0, ddmardy_n}, 16'h1);
          stall <= 1'b0;
        end
      join_none
    do_cmd(UDC_CMD_WRITE_DMA, 3'h0, n, |bm);
    cmp_val({15'h0, status.crc_err}, {15'h0, |bm});
    cmp_val({8'h0, status.err_burst}, {8'h0, eb});
    cmp_val({15'h0, intrq}, 16'h1);
    i_intrq_clr <= 1'b1;
    @(posedge i_clk);
    i_intrq_clr <= 1'b0;
    repeat (2) @(posedge i_clk);
    cmp_val({15'h0, intrq}, 16'h0);
  endtask

  // random drain, held off while a scenario stalls the reader
  always @(posedge i_clk)
    i_rd_ready <= stall ? 1'b0 : 1'($random(seed));

  // take the oldest note whenever a word or a completion shows up
  always @(posedge i_clk)
  begin
    if (i_arst_n && rd_valid && i_rd_ready)
      cmp_val(rd_data, word_q.size() > 0 ? word_q.pop_front() : ~rd_data);
    if (i_arst_n && done)
      cmp_val({15'h0, fail}, {15'h0, done_q.size() > 0 ? done_q.pop_front() : ~fail});
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    cmp_val(ident, 16'h007f);
    cmp_val({13'h0, mw}, 16'h0);
    do_cmd(UDC_CMD_WRITE_DMA, 3'h0, 16'h2, 1'b1);
    for (int m = 0; m < 8; m++)
    begin
      do_cmd(UDC_CMD_SET_MODE, 3'(m), 16'h0, m == 7);
      cmp_val(ident, {8'h1 << (m == 7 ? 6 : m), 8'h7f});
    end
    do_cmd(UDC_CMD_SET_MODE, 3'h3, 16'h0, 1'b0);
    do_cmd(UDC_CMD_REVERT_OFF, 3'h0, 16'h0, 1'b0);
    do_cmd(UDC_CMD_SOFT_RST, 3'h0, 16'h0, 1'b0);
    do_cmd(UDC_CMD_DEV_RST, 3'h0, 16'h0, 1'b0);
    cmp_val(ident, 16'h087f);
    run_dma(16'h4, 16'h4, 8'h00, 1'b0, 8'h0);
    run_dma(16'h6, 16'h2, 8'h03, 1'b0, 8'h1);
    run_dma(16'h6, 16'h2, 8'h02, 1'b0, 8'h2);
    run_dma(16'h8, 16'h8, 8'h00, 1'b1, 8'h0);
    repeat (50) @(posedge i_clk);
    cmp_val(16'(word_q.size()), 16'h0);
    do_cmd(UDC_CMD_REVERT_ON, 3'h0, 16'h0, 1'b0);
    do_cmd(UDC_CMD_DEV_RST, 3'h0, 16'h0, 1'b0);
    cmp_val({15'h0, status.udma_vld}, 16'h0);
    do_cmd(UDC_CMD_SET_MODE, 3'h2, 16'h0, 1'b0);
    hw_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    hw_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    cmp_val(ident, 16'h007f);
    cmp_val({15'h0, status.revert_en}, 16'h0);
    test_done();
  end

  // watchdog: the whole run needs well under this span
  initial
  begin
    #600000;
    failures++;
    test_done();
  end
endmodule

// [udc_fifo.sv]
/*
  small synchronous fifo with valid/ready on both sides and a fill level.
  assumes one clock; read data comes from a register.
*/
`timescale 1ns/1ns
module udc_fifo
  import udc_pkg::*;
#(
  parameter int W = 16,
  parameter int D = 4
)
(
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_in_valid,
  output logic                      o_in_ready,
  input  wire logic [W-1:0]         i_in_data,
  output logic                      o_out_valid,
  input  wire logic                 i_out_ready,
  output logic [W-1:0]              o_out_data,
  output logic [$clog2(D+1)-1:0]    o_level
);

  localparam int AW = $clog2(D);
  localparam int LW = $clog2(D+1);

  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [LW-1:0] cnt_ff;
  logic [W-1:0]  out_ff;
  logic          out_vld_ff;
  logic          push;
  logic          pop;

  // ==========================================================
  // handshakes
  // the head moves into out_ff whenever that register is empty or being drained,
  // so the reader sees data and valid straight from flip-flops
  assign o_in_ready  = (cnt_ff != LW'(D));
  assign o_out_valid = out_vld_ff;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = (cnt_ff != '0) & (~out_vld_ff | i_out_ready);
  assign o_out_data  = out_ff;
  assign o_level     = cnt_ff;

  // storage has no reset; pointers and count do
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_ff[wr_ff] <= i_in_data;
    end
    if (pop)
    begin
      out_ff <= mem_ff[rd_ff];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
      out_vld_ff <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ff <= (wr_ff == AW'(D-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ff <= (rd_ff == AW'(D-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + LW'(push) - LW'(pop);
      out_vld_ff <= pop | (out_vld_ff & ~i_out_ready);
    end
  end

endmodule

// [udc_host_model.sv]
/*
  behavioural host for data-out bursts: words base+index, crc at burst end.
  assumes the device pauses through ddmardy_n; strobe edges are 80 ns apart.
*/
`timescale 1ns/1ns
module udc_host_model
  import udc_pkg::*;
(
  input  wire logic        i_dmarq,
  input  wire logic        i_ddmardy_n,
  input  wire logic        i_hw_rst_n,
  input  wire logic [15:0] i_base,
  input  wire logic [15:0] i_total,
  input  wire logic [15:0] i_burst_len,
  input  wire logic [7:0]  i_bad_mask,
  output udc_pins_s        o_pins
);
  logic        dmack_n;
  logic        strobe;
  logic [15:0] hd;
  logic [15:0] crc;
  int          widx;
  int          bidx;
  int          k;
  // one msb-first step per word, kept apart from the device's own code
  function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = c[15] ^ d[i] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction
  assign o_pins = '{hw_rst_n: i_hw_rst_n, dmack_n: dmack_n, stop: 1'b0, hstrobe: strobe, hd: hd};
  // burst loop: strobe stands still between bursts, released data is inverted
  initial
  begin
    dmack_n = 1'b1;
    strobe  = 1'b0;
    hd      = 16'h0;
    widx    = 0;
    bidx    = 0;
    forever
    begin
      wait (i_dmarq === 1'b1);
      // two ns off the clock grid so pin changes never meet a sampling edge
      #42 dmack_n = 1'b0;
      crc = 16'hffff;
      k   = 0;
      #80;
      while (k < i_burst_len && widx < i_total)
      begin
        while (i_ddmardy_n !== 1'b0) #10;
        hd  = i_base + widx[15:0];
        crc = step(crc, hd);
        #40 strobe = ~strobe;
        #40 k++;
        widx++;
      end
      hd = i_bad_mask[bidx] ? ~crc : crc;
      #40 dmack_n = 1'b1;
      #40 hd = ~hd;
      bidx++;
      if (widx >= i_total)
      begin
        widx = 0;
        bidx = 0;
      end
      #160;
    end
  end
endmodule

// [udc_pkg.sv]
/*
  shared constants, commands and carriers of the ultra dma mode and crc control block.
  assumes a single 100 MHz clock domain on the device side; the host drives the pin carrier without a clock.
*/
package udc_pkg;

  // ==========================================================
  // widths and limits
  localparam int          UDC_DW       = 16;
  localparam int          UDC_MODE_W   = 3;
  localparam int          UDC_CNT_W    = 16;
  localparam int          UDC_BURST_W  = 8;
  localparam int          UDC_SYNC_N   = 2;
  localparam logic [2:0]  UDC_MAX_MODE = 3'h6;
  localparam logic [2:0]  UDC_MW_DFLT  = 3'h0;
  localparam logic        UDC_REVERT_RST = 1'b0;
  localparam int          UDC_PAUSE_LVL  = 2;

  // ==========================================================
  // identify word layout: supported set low, selected mode high
  localparam int          UDC_ID_SUP_LSB = 0;
  localparam int          UDC_ID_SEL_LSB = 8;

  // ==========================================================
  // crc defaults
  localparam logic [15:0] UDC_CRC_POLY = 16'h1021;
  localparam logic [15:0] UDC_CRC_SEED = 16'hffff;

  // ==========================================================
  // commands from the device's command decoder
  typedef enum logic [2:0]
  {
    UDC_CMD_SET_MODE,
    UDC_CMD_REVERT_ON,
    UDC_CMD_REVERT_OFF,
    UDC_CMD_SOFT_RST,
    UDC_CMD_DEV_RST,
    UDC_CMD_WRITE_DMA
  } udc_cmd_e;

  typedef struct packed
  {
    udc_cmd_e               op;
    logic [UDC_MODE_W-1:0]  mode;
    logic [UDC_CNT_W-1:0]   count;
  } udc_cmd_s;

  // host pins as seen by the device
  typedef struct packed
  {
    logic                   hw_rst_n;
    logic                   dmack_n;
    logic                   stop;
    logic                   hstrobe;
    logic [UDC_DW-1:0]      hd;
  } udc_pins_s;

  typedef struct packed
  {
    logic                   udma_vld;
    logic [UDC_MODE_W-1:0]  udma_mode;
    logic                   revert_en;
    logic                   crc_err;
    logic [UDC_BURST_W-1:0] err_burst;
  } udc_status_s;

endpackage
